// >>> serial_flash_powerup_gate.sv
// Power-on and reset entry gate of a serial flash slave interface.
// Assumes a 40 MHz timebase on clk, the serial clock on sck and a supply
// monitor that drives reset_release_threshold_met high above the threshold.
`timescale 1ns/10ps
`default_nettype none

module serial_flash_powerup_gate
    import serial_flash_powerup_pkg::*;
#(
    parameter int READ_DELAY_CYCLES = POWER_TO_READ_CYCLES,
    parameter int WRITE_DELAY_CYCLES = POWER_TO_WRITE_CYCLES
)
(
    // Timebase clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial link pins
    input wire logic sck,
    input wire logic chip_select_low_active_n,
    input wire logic si,
    // Supply monitor
    input wire logic reset_release_threshold_met,
    // Serial output enable
    output var logic so_oe,
    // Command results
    output var logic read_grant,
    output var logic write_start,
    output var logic [7:0] command_opcode,
    // Status
    output var logic spi_mode_3,
    output var logic in_reset,
    output var logic read_allowed,
    output var logic write_allowed,
    output var logic standby,
    output var logic active
);

    // ------------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------------
    localparam int RD_W = $clog2(READ_DELAY_CYCLES + 1);
    localparam int WR_W = $clog2(WRITE_DELAY_CYCLES + 1);

    if (READ_DELAY_CYCLES < 1 || WRITE_DELAY_CYCLES < READ_DELAY_CYCLES)
    begin : g_check
        $error("delay counts must be positive and write not below read");
    end

    // ------------------------------------------------------------------------
    // Link domain and crossing
    // ------------------------------------------------------------------------
    opcode_link_if link ();

    opcode_capture u_capture
    (
        .sck(sck),
        .chip_select_low_active_n(chip_select_low_active_n),
        .si(si),
        .link(link.capture)
    );

    logic [SYNC_WIDTH-1:0] sync_in;
    logic [SYNC_WIDTH-1:0] sync_out;

    always_comb
    begin
        sync_in = '0;
        sync_in[LANE_CS] = chip_select_low_active_n;
        sync_in[LANE_SCK] = sck;
        sync_in[LANE_POR] = reset_release_threshold_met;
        sync_in[LANE_CAPTURED] = link.captured;
    end

    pin_sync
    #(
        .WIDTH(SYNC_WIDTH),
        .RESET_VALUE(SYNC_RESET_VALUE)
    )
    u_sync
    (
        .clk(clk),
        .rst_n(rst_n),
        .din(sync_in),
        .dout(sync_out)
    );

    logic cs_n_s;
    logic sck_s;
    logic por_ok_s;
    logic captured_s;

    assign cs_n_s = sync_out[LANE_CS];
    assign sck_s = sync_out[LANE_SCK];
    assign por_ok_s = sync_out[LANE_POR];
    assign captured_s = sync_out[LANE_CAPTURED];

    // ------------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------------
    logic cs_n_prev;
    logic captured_prev;
    logic cs_fall;
    logic cs_rise;
    logic cmd_event;

    assign cs_fall = cs_n_prev & ~cs_n_s;
    assign cs_rise = ~cs_n_prev & cs_n_s;
    assign cmd_event = ~captured_prev & captured_s;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cs_n_prev <= 1'b1;
            captured_prev <= 1'b0;
        end
        else
        begin
            cs_n_prev <= cs_n_s;
            captured_prev <= captured_s;
        end
    end

    // ------------------------------------------------------------------------
    // Power-up delay counters
    // ------------------------------------------------------------------------
    logic [RD_W-1:0] read_count;
    logic [WR_W-1:0] write_count;
    logic [RD_W-1:0] next_read_count;
    logic [WR_W-1:0] next_write_count;
    logic read_done;
    logic write_done;

    assign read_done = (read_count == RD_W'(READ_DELAY_CYCLES));
    assign write_done = (write_count == WR_W'(WRITE_DELAY_CYCLES));

    always_comb
    begin
        next_read_count = read_count;
        next_write_count = write_count;
        if (!por_ok_s)
        begin
            next_read_count = '0;
            next_write_count = '0;
        end
        else
        begin
            if (!read_done)
            begin
                next_read_count = read_count + RD_W'(1);
            end
            if (!write_done)
            begin
                next_write_count = write_count + WR_W'(1);
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            read_count <= '0;
            write_count <= '0;
        end
        else
        begin
            read_count <= next_read_count;
            write_count <= next_write_count;
        end
    end

    // ------------------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------------------
    power_state_type state;
    power_state_type next_state;

    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_POR_HOLD:
            begin
                if (por_ok_s)
                begin
                    next_state = ST_POWERUP;
                end
            end
            ST_POWERUP:
            begin
                if (write_done)
                begin
                    next_state = cs_n_s ? ST_STANDBY : ST_ACTIVE;
                end
            end
            ST_STANDBY:
            begin
                if (!cs_n_s)
                begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE:
            begin
                if (cs_n_s)
                begin
                    next_state = ST_STANDBY;
                end
            end
        endcase
        if (!por_ok_s)
        begin
            next_state = ST_POR_HOLD;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state <= ST_POR_HOLD;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------------
    // Frame arming, mode choice and command gating
    // ------------------------------------------------------------------------
    logic armed;
    logic pending_write;
    logic next_armed;
    logic next_pending_write;
    logic next_so_oe;
    logic next_read_grant;
    logic next_write_start;
    logic [7:0] next_command_opcode;
    logic next_spi_mode_3;
    logic live;

    assign live = (state != ST_POR_HOLD) && por_ok_s;

    always_comb
    begin
        next_armed = armed;
        next_pending_write = pending_write;
        next_so_oe = so_oe;
        next_read_grant = 1'b0;
        next_write_start = 1'b0;
        next_command_opcode = command_opcode;
        next_spi_mode_3 = spi_mode_3;
        if (cs_fall && live)
        begin
            next_armed = 1'b1;
            next_spi_mode_3 = sck_s;
        end
        if (cs_rise)
        begin
            next_armed = 1'b0;
            next_so_oe = 1'b0;
        end
        if (cmd_event && armed && live && !cs_n_s)
        begin
            next_command_opcode = link.opcode;
            if (is_read_opcode(link.opcode))
            begin
                // Reads that come too early get no answer.
                if (read_done)
                begin
                    next_read_grant = 1'b1;
                    next_so_oe = 1'b1;
                end
            end
            else if (write_done)
            begin
                next_write_start = 1'b1;
            end
            else
            begin
                next_pending_write = 1'b1;
            end
        end
        if (pending_write && write_done && live)
        begin
            next_pending_write = 1'b0;
            next_write_start = 1'b1;
        end
        if (!live)
        begin
            next_armed = 1'b0;
            next_pending_write = 1'b0;
            next_so_oe = 1'b0;
            next_read_grant = 1'b0;
            next_write_start = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            armed <= 1'b0;
            pending_write <= 1'b0;
            so_oe <= 1'b0;
            read_grant <= 1'b0;
            write_start <= 1'b0;
            command_opcode <= 8'h00;
            spi_mode_3 <= 1'b0;
        end
        else
        begin
            armed <= next_armed;
            pending_write <= next_pending_write;
            so_oe <= next_so_oe;
            read_grant <= next_read_grant;
            write_start <= next_write_start;
            command_opcode <= next_command_opcode;
            spi_mode_3 <= next_spi_mode_3;
        end
    end

    // ------------------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------------------
    logic next_in_reset;
    logic next_read_allowed;
    logic next_write_allowed;
    logic next_standby;
    logic next_active;

    always_comb
    begin
        next_in_reset = (next_state == ST_POR_HOLD);
        next_read_allowed = (next_state != ST_POR_HOLD) && (next_read_count == RD_W'(READ_DELAY_CYCLES));
        next_write_allowed = (next_state == ST_STANDBY) || (next_state == ST_ACTIVE);
        next_standby = (next_state == ST_STANDBY);
        next_active = (next_state == ST_ACTIVE);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            in_reset <= 1'b1;
            read_allowed <= 1'b0;
            write_allowed <= 1'b0;
            standby <= 1'b0;
            active <= 1'b0;
        end
        else
        begin
            in_reset <= next_in_reset;
            read_allowed <= next_read_allowed;
            write_allowed <= next_write_allowed;
            standby <= next_standby;
            active <= next_active;
        end
    end

endmodule : serial_flash_powerup_gate

`default_nettype wire

// >>> serial_flash_powerup_pkg.sv
// Constants, types and helpers shared by the power-up gate and its parts.
// Assumes a 40 MHz timebase clock and an 8-bit opcode shifted in MSB first.
package serial_flash_powerup_pkg;

    // ------------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 40;
    localparam int POWER_TO_READ_DELAY_US = 70;
    localparam int POWER_TO_WRITE_DELAY_MS = 3;
    // Least time: the product is exact, so rounding up changes nothing.
    localparam int POWER_TO_READ_CYCLES = (POWER_TO_READ_DELAY_US * CLK_FREQ_MHZ + 0);
    // Longest time: rounded down, which the integer product already is.
    localparam int POWER_TO_WRITE_CYCLES = POWER_TO_WRITE_DELAY_MS * 1000 * CLK_FREQ_MHZ;

    // ------------------------------------------------------------------------
    // Serial framing
    // ------------------------------------------------------------------------
    localparam int OPCODE_BITS = 8;
    localparam logic [2:0] OPCODE_LAST_BIT = 3'h7;
    localparam int READ_OPCODE_COUNT = 6;
    localparam logic [7:0] READ_OPCODES [READ_OPCODE_COUNT] =
        '{8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD6, 8'hD7};

    // ------------------------------------------------------------------------
    // Synchroniser lanes and their reset values
    // ------------------------------------------------------------------------
    localparam int SYNC_WIDTH = 4;
    localparam int LANE_CS = 0;
    localparam int LANE_SCK = 1;
    localparam int LANE_POR = 2;
    localparam int LANE_CAPTURED = 3;
    localparam logic [3:0] SYNC_RESET_VALUE = 4'h1;

    // ------------------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ST_POR_HOLD = 2'b00,
        ST_POWERUP = 2'b01,
        ST_STANDBY = 2'b11,
        ST_ACTIVE = 2'b10
    } power_state_type;

    // Opcodes outside the read set are held back like program or erase.
    function automatic logic is_read_opcode(input logic [7:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < READ_OPCODE_COUNT; i++)
        begin
            if (code == READ_OPCODES[i])
            begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : is_read_opcode

endpackage : serial_flash_powerup_pkg

// >>> opcode_link_if.sv
// Carries the captured opcode from the serial clock domain to the timebase.
// Assumes the opcode is stable for as long as the captured level is high.
`timescale 1ns/10ps
`default_nettype none

interface opcode_link_if;
    logic captured;
    logic [7:0] opcode;

    modport capture (output captured, output opcode);
    modport consumer (input captured, input opcode);
endinterface : opcode_link_if

`default_nettype wire

// >>> pin_sync.sv
// Three-stage synchroniser; a lane changes once stages two and three agree.
// Assumes each lane is a level that holds for several clock periods.
`timescale 1ns/10ps
`default_nettype none

module pin_sync
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Lanes
    input wire logic [WIDTH-1:0] din,
    output var logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_dout;

    if (WIDTH < 1)
    begin : g_check
        $error("pin_sync needs at least one lane");
    end

    always_comb
    begin
        next_dout = (stage2 & stage3) | (dout & (stage2 | stage3));
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            stage1 <= RESET_VALUE;
            stage2 <= RESET_VALUE;
            stage3 <= RESET_VALUE;
            dout <= RESET_VALUE;
        end
        else
        begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
            dout <= next_dout;
        end
    end

endmodule : pin_sync

`default_nettype wire

// >>> opcode_capture.sv
// Shifts in the first eight serial bits of a frame on the serial clock.
// Assumes the chip select pin is high between frames; that level clears it.
`timescale 1ns/10ps
`default_nettype none

module opcode_capture
    import serial_flash_powerup_pkg::*;
(
    // Link pins
    input wire logic sck,
    input wire logic chip_select_low_active_n,
    input wire logic si,
    // Toward the timebase
    opcode_link_if.capture link
);

    logic [2:0] bit_count;
    logic [6:0] shift;
    logic captured;
    logic [7:0] opcode;
    logic [2:0] next_bit_count;
    logic [6:0] next_shift;
    logic next_captured;
    logic [7:0] next_opcode;

    // Both modes sample input on the rising serial clock edge.
    always_comb
    begin
        next_bit_count = bit_count;
        next_shift = shift;
        next_captured = captured;
        next_opcode = opcode;
        if (!captured)
        begin
            next_shift = {shift[5:0], si};
            next_bit_count = bit_count + 3'h1;
            if (bit_count == OPCODE_LAST_BIT)
            begin
                next_opcode = {shift, si};
                next_captured = 1'b1;
            end
        end
    end

    // A high chip select ends the frame at once, even with the clock stopped.
    always_ff @(posedge sck or posedge chip_select_low_active_n)
    begin
        if (chip_select_low_active_n)
        begin
            bit_count <= 3'h0;
            shift <= 7'h00;
            captured <= 1'b0;
            opcode <= 8'h00;
        end
        else
        begin
            bit_count <= next_bit_count;
            shift <= next_shift;
            captured <= next_captured;
            opcode <= next_opcode;
        end
    end

    assign link.captured = captured;
    assign link.opcode = opcode;

endmodule : opcode_capture

`default_nettype wire

// >>> host_spi.sv
// Host SPI controller model: drives chip select, serial clock and data in.
// Assumes the caller spaces frames; the serial clock only runs within frames.
`timescale 1ns/10ps
`default_nettype none

module host_spi
(
    // Link pins
    output var logic sck,
    output var logic chip_select_low_active_n,
    output var logic si
);
    initial
    begin
        sck = 1'b0;
        chip_select_low_active_n = 1'b1;
        si = 1'b0;
    end

    // Sends the top nbits of code MSB first at a 15 ns serial clock.
    task automatic frame(input logic [7:0] code, input int nbits, input logic mode3);
        #3.1;
        sck = mode3;
        #200;
        chip_select_low_active_n = 1'b0;
        #200;
        for (int i = 7; i > 7 - nbits; i--)
        begin
            sck = 1'b0;
            si = code[i];
            #7.5;
            sck = 1'b1;
            #7.5;
        end
        sck = mode3;
        si = ~si;
        #300;
        chip_select_low_active_n = 1'b1;
        #300;
    endtask : frame
endmodule : host_spi

`default_nettype wire

// >>> serial_flash_powerup_gate_properties.sv
// Checker for the power-up gate, watching only its top-level ports.
// Assumes all checks run in the timebase clock domain.
`timescale 1ns/10ps
`default_nettype none

module serial_flash_powerup_gate_checker
#(
    parameter int READ_DELAY_CYCLES = 2800,
    parameter int WRITE_DELAY_CYCLES = 120000
)
(
    // Inputs of the gate
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic chip_select_low_active_n,
    input wire logic reset_release_threshold_met,
    // Outputs of the gate
    input wire logic so_oe,
    input wire logic read_grant,
    input wire logic write_start,
    input wire logic spi_mode_3,
    input wire logic in_reset,
    input wire logic read_allowed,
    input wire logic write_allowed,
    input wire logic standby,
    input wire logic active
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------------------
    // Cycles since the supply monitor released
    // ------------------------------------------------------------------------
    int por_count;
    int next_por_count;

    always_comb
    begin
        next_por_count = por_count;
        if (!reset_release_threshold_met)
            next_por_count = 0;
        else if (por_count < WRITE_DELAY_CYCLES + 16)
            next_por_count = por_count + 1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            por_count <= 0;
        else
            por_count <= next_por_count;
    end

    // ------------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------------
    a_reset_outputs: assert property ($rose(rst_n) |-> in_reset && !so_oe && !write_allowed)
        else $error("outputs not at reset values");
    a_oe_cause: assert property ($rose(so_oe) |-> read_grant)
        else $error("output enabled without a read grant");
    a_oe_release: assert property (chip_select_low_active_n [*7] |-> !so_oe)
        else $error("output still enabled after chip select rise");
    a_por_silent: assert property (in_reset |-> !read_grant && !write_start && !so_oe)
        else $error("command answered in power-on reset");
    a_por_hold: assert property (!reset_release_threshold_met [*5] |=> in_reset && !read_allowed)
        else $error("power-on reset not held");
    a_single_pulse: assert property (read_grant || write_start |=> !read_grant && !write_start)
        else $error("command pulse longer than one cycle");
    a_mode_select: assert property ($fell(chip_select_low_active_n) && write_allowed
        |-> ##8 spi_mode_3 == $past(sck, 8))
        else $error("mode not taken from idle clock");
    a_read_gated: assert property (read_grant |-> read_allowed && so_oe && !in_reset)
        else $error("read granted before read delay");
    // The grant flags lag a supply drop by the synchroniser, so only their rise is timed.
    a_read_delay: assert property ($rose(read_allowed)
        |-> por_count >= READ_DELAY_CYCLES)
        else $error("read delay too short");
    a_read_bound: assert property (por_count == READ_DELAY_CYCLES + 12 |-> read_allowed)
        else $error("read delay too long");
    a_write_gated: assert property (write_start |-> write_allowed && !in_reset)
        else $error("write started before write delay");
    a_write_delay: assert property ($rose(write_allowed)
        |-> por_count >= WRITE_DELAY_CYCLES)
        else $error("write delay too short");
    a_write_bound: assert property (por_count == WRITE_DELAY_CYCLES + 12 |-> write_allowed)
        else $error("write delay too long");
    a_standby_state: assert property ((write_allowed && chip_select_low_active_n) [*6]
        |-> standby && !active)
        else $error("standby not entered with select high");
    a_active_state: assert property ((write_allowed && !chip_select_low_active_n) [*6]
        |-> active && !standby)
        else $error("active not entered with select low");

    c_read_mode3: cover property (read_grant && spi_mode_3);
    c_write: cover property (write_start);
    c_standby_active: cover property (standby ##1 active);
endmodule : serial_flash_powerup_gate_checker

bind serial_flash_powerup_gate serial_flash_powerup_gate_checker #(
    .READ_DELAY_CYCLES(READ_DELAY_CYCLES),
    .WRITE_DELAY_CYCLES(WRITE_DELAY_CYCLES)
) checker_u (.clk(clk), .rst_n(rst_n), .sck(sck),
    .chip_select_low_active_n(chip_select_low_active_n),
    .reset_release_threshold_met(reset_release_threshold_met), .so_oe(so_oe),
    .read_grant(read_grant), .write_start(write_start), .spi_mode_3(spi_mode_3),
    .in_reset(in_reset), .read_allowed(read_allowed), .write_allowed(write_allowed),
    .standby(standby), .active(active));

`default_nettype wire

// >>> tb.sv
// Self-checking bench for the power-up gate with a host SPI model.
// Assumes shortened power-up delays of 40 and 400 timebase cycles.
`timescale 1ns/10ps
`default_nettype none

module tb;
    localparam int READ_CYC = 40;
    localparam int WRITE_CYC = 400;
    localparam logic [7:0] READS [6] = '{8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD6, 8'hD7};

    logic clk;
    logic rst_n;
    logic threshold_met;
    logic sck;
    logic cs_n;
    logic si;
    logic so_oe;
    logic read_grant;
    logic write_start;
    logic [7:0] command_opcode;
    logic spi_mode_3;
    logic in_reset;
    logic read_allowed;
    logic write_allowed;
    logic standby;
    logic active;
    logic [7:0] op;
    logic [8:0] expq [$];
    int err_count;
    int tests_run;

    serial_flash_powerup_gate #(.READ_DELAY_CYCLES(READ_CYC), .WRITE_DELAY_CYCLES(WRITE_CYC))
    dut_u (.clk(clk), .rst_n(rst_n), .sck(sck), .chip_select_low_active_n(cs_n), .si(si),
        .reset_release_threshold_met(threshold_met), .so_oe(so_oe),
        .read_grant(read_grant), .write_start(write_start), .command_opcode(command_opcode),
        .spi_mode_3(spi_mode_3), .in_reset(in_reset), .read_allowed(read_allowed),
        .write_allowed(write_allowed), .standby(standby), .active(active));

    host_spi host_u (.sck(sck), .chip_select_low_active_n(cs_n), .si(si));

    always #12.5 clk = ~clk;

    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict

    // Pops the oldest expected command whenever a pulse appears.
    always @(posedge clk)
    begin
        #1;
        if (read_grant === 1'b1 || write_start === 1'b1)
        begin
            check("command", {write_start, command_opcode},
                expq.size() != 0 ? expq.pop_front() : {9{1'bX}});
            check("so_oe at grant", 9'(so_oe), 9'(read_grant));
        end
    end

    initial
    begin
        #500000;
        err_count++;
        print_verdict();
    end

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        threshold_met = 1'b0;
        err_count = 0;
        tests_run = 0;
        void'($urandom(32'h4377B4B8));
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check("reset state", {7'h00, in_reset, so_oe}, 9'h002);
        host_u.frame(8'hD1, 8, 1'b0);
        $display("test por_hold done");
        @(negedge clk);
        threshold_met = 1'b1;
        host_u.frame(8'hD2, 8, 1'b1);
        op = 8'($urandom);
        if (op[7:4] == 4'hD)
            op[7:4] = 4'hC;
        expq.push_back({1'b1, op});
        host_u.frame(op, 8, 1'b0);
        repeat (WRITE_CYC) @(negedge clk);
        check("pending", 9'(expq.size()), 9'h000);
        check("standby", {7'h00, standby, active}, 9'h002);
        $display("test power_up_delays done");
        for (int i = 0; i < 12; i++)
        begin
            expq.push_back({1'b0, READS[i % 6]});
            host_u.frame(READS[i % 6], 8, i[0]);
            check("mode", 9'(spi_mode_3), 9'(i[0]));
            check("so_oe release", 9'(so_oe), 9'h000);
        end
        $display("test reads done");
        for (int i = 0; i < 6; i++)
        begin
            op = 8'($urandom);
            if (op[7:4] == 4'hD)
                op[7:4] = 4'hC;
            if (i == 5)
                host_u.frame(op, 5, 1'b1);
            else
            begin
                expq.push_back({1'b1, op});
                host_u.frame(op, 8, i[0]);
            end
        end
        check("pending", 9'(expq.size()), 9'h000);
        $display("test writes done");
        @(negedge clk);
        rst_n = 1'b0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check("rerun reset", {6'h00, in_reset, write_allowed, so_oe}, 9'h004);
        repeat (READ_CYC + 12) @(negedge clk);
        expq.push_back({1'b0, 8'hD7});
        host_u.frame(8'hD7, 8, 1'b0);
        $display("test mid_reset done");
        threshold_met = 1'b0;
        repeat (8) @(negedge clk);
        check("por again", {6'h00, in_reset, read_allowed, write_allowed}, 9'h004);
        host_u.frame(8'hD3, 8, 1'b0);
        check("pending", 9'(expq.size()), 9'h000);
        $display("test por_drop done");
        print_verdict();
    end
endmodule : tb

`default_nettype wire
